// >>> inc/spm_defines.vh
// Shared constants for the sink power state manager.
// How it works
// (R1) Minimum power is min voltage times max current; op and max use max voltage.
// (R2) Exactly one of Active, Idle or Sleep is held at any time.
// (R3) State moves happen by themselves from activity and attach status.
// (R4) Deep standby is a flag inside Idle, never a fourth state.
// (R5) Active drops to Idle only after quiet interval T with no activity event.
// (R6) Sleep keeps watching for attach and wakes on a new connection.
// (R7) Sink path on in Active and Idle outside deep standby; CC1 Rp 3.0A only then; CC2 always open.
// (R8) Die over-temperature rising past threshold shuts everything but supervision.
// (R9) Recovery only when temperature drops below threshold minus hysteresis.
// (R10) Each internal power path has its own over-temperature monitor.
// (R11) Contracts at 5, 9, 12, 15 or 20 volts, up to 5 amperes.
// (R12) Voltage and current needs come only from the strap inputs.
// (R13) Min voltage strap decodes 0..4 to 5,9,12,15,20 V; 5..7 reserved.
// (R14) Any activity restarts the idle counter and pulls Idle back to Active.
// (R15) Thermal shutdown forces the path off and CC to Sleep values.
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH
`define SPM_CLK_MHZ     50
`define SPM_T_IDLE_US   1000
`define SPM_T_STBY_US   1000
`define SPM_ST_ACTIVE   2'h0
`define SPM_ST_IDLE     2'h1
`define SPM_ST_SLEEP    2'h2
`define SPM_TSD_THRESH  8'h7D
`define SPM_TSD_HYST    8'h0F
`define SPM_A_CTRL      8'h00
`define SPM_A_STATUS    8'h04
`define SPM_A_POWER     8'h08
`define SPM_A_VOLTS     8'h0C
`define SPM_A_IRQ_STAT  8'h10
`define SPM_A_IRQ_MASK  8'h14
`define SPM_A_STRAPS    8'h18
`define SPM_IRQ_W       5
`define SPM_IRQ_STATE   0
`define SPM_IRQ_TSD     1
`define SPM_IRQ_PATH_OT 2
`define SPM_IRQ_ATTACH  3
`define SPM_IRQ_STRAP   4
`define SPM_CTRL_STBY   0
`define SPM_MINV_MAX    3'h4
`define SPM_VOLT_5      5'h05
`define SPM_VOLT_9      5'h09
`define SPM_VOLT_12     5'h0C
`define SPM_VOLT_15     5'h0F
`define SPM_VOLT_20     5'h14
`define SPM_CUR_1P5     4'h3
`define SPM_CUR_3       4'h6
`define SPM_CUR_4       4'h8
`define SPM_CUR_5       4'hA
`endif

// >>> core/spm_sync.v
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module spm_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // The first stage feeds only the second, so metastability cannot reach any logic.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // spm_sync

// >>> core/spm_power_calc.v
// Strap decode and extended sink power figures in half-watt units.
`timescale 1ns/10ps
`include "spm_defines.vh"
module spm_power_calc (
  input  wire [2:0] min_voltage_strap,
  input  wire [2:0] max_voltage_strap,
  input  wire [2:0] max_current_strap,
  output reg  [4:0] min_volt,
  output reg  [4:0] max_volt,
  output reg  [3:0] max_cur,
  output wire       strap_bad,
  output wire [7:0] min_power,
  output wire [7:0] max_power
);
  wire [8:0] min_p;
  wire [8:0] max_p;

  // Reserved minimum codes fall back to 5 V so the sink still draws safe power. [R13] [R12]
  always @* begin
    case (min_voltage_strap)
      3'h1:    min_volt = `SPM_VOLT_9;
      3'h2:    min_volt = `SPM_VOLT_12;
      3'h3:    min_volt = `SPM_VOLT_15;
      3'h4:    min_volt = `SPM_VOLT_20;
      default: min_volt = `SPM_VOLT_5;
    endcase
  end

  // Maximum voltage codes pair up, both codes of each pair naming the same level. [R11]
  always @* begin
    case (max_voltage_strap[2:1])
      2'h0:    max_volt = `SPM_VOLT_9;
      2'h1:    max_volt = `SPM_VOLT_12;
      2'h2:    max_volt = `SPM_VOLT_15;
      default: max_volt = `SPM_VOLT_20;
    endcase
  end

  // Maximum current in half-ampere steps, at most 5 A. [R11]
  always @* begin
    case (max_current_strap[1:0])
      2'h0:    max_cur = `SPM_CUR_1P5;
      2'h1:    max_cur = `SPM_CUR_3;
      2'h2:    max_cur = `SPM_CUR_4;
      default: max_cur = `SPM_CUR_5;
    endcase
  end

  assign strap_bad = (min_voltage_strap > `SPM_MINV_MAX);
  assign min_p     = min_volt * max_cur; // [R1]
  assign max_p     = max_volt * max_cur; // [R1]
  assign min_power = min_p[7:0];
  assign max_power = max_p[7:0];
endmodule // spm_power_calc

// >>> core/spm_top.v
// Power state machine, thermal gating, power figures and register port.
`timescale 1ns/10ps
`include "spm_defines.vh"
module spm_top #(
  parameter        PATHS    = 2,
  parameter [31:0] IDLE_CYC = `SPM_T_IDLE_US * `SPM_CLK_MHZ,
  parameter [31:0] STBY_CYC = `SPM_T_STBY_US * `SPM_CLK_MHZ
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire [7:0]       addr,
  input  wire [31:0]      wr_data,
  input  wire             wr_stb,
  input  wire             rd_stb,
  output reg  [31:0]      rd_data,
  input  wire [2:0]       min_voltage_strap,
  input  wire [2:0]       max_voltage_strap,
  input  wire [2:0]       operating_current_strap,
  input  wire [2:0]       max_current_strap,
  input  wire             pd_msg_evt,
  input  wire             cc_change_evt,
  input  wire             gpio_evt,
  input  wire             i2c_evt,
  input  wire             volt_alert,
  input  wire             fault_alert,
  input  wire             attach_pin,
  input  wire [7:0]       die_temp,
  input  wire [PATHS-1:0] path_overtemp,
  output reg  [1:0]       pwr_state,
  output reg              deep_standby,
  output reg              thermal_shutdown,
  output reg              internal_hv_sink_path,
  output reg              external_path_gate_drive,
  output reg              cc1_rp_en,
  output reg              cc2_rp_en,
  output reg  [7:0]       min_power_figure,
  output reg  [7:0]       op_power_figure,
  output reg  [7:0]       max_power_figure,
  output reg              irq
);
  wire [11:0]      strap_s;
  wire             attach_s;
  wire [PATHS-1:0] path_ot_s;
  wire [4:0]       min_volt;
  wire [4:0]       max_volt;
  wire [3:0]       max_cur;
  wire             strap_bad;
  wire [7:0]       min_p;
  wire [7:0]       max_p;
  wire             activity;
  wire             tsd_set;
  wire             tsd_clr;
  wire [7:0]       tsd_low;
  wire             run;

  reg [1:0]            state_q;
  reg [1:0]            state_d;
  reg [31:0]           idle_cnt_q;
  reg [31:0]           stby_cnt_q;
  reg                  stby_q;
  reg                  tsd_q;
  reg                  attach_q;
  reg [PATHS-1:0]      path_ot_q;
  reg                  strap_bad_q;
  reg                  stby_en_q;
  reg [`SPM_IRQ_W-1:0] irq_stat_q;
  reg [`SPM_IRQ_W-1:0] irq_mask_q;
  reg [`SPM_IRQ_W-1:0] irq_evt;
  reg [31:0]           rd_d;

  spm_sync #(
    .W (12)
  ) u_strap_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({operating_current_strap, max_current_strap, max_voltage_strap, min_voltage_strap}),
    .dout    (strap_s)
  );

  spm_sync #(
    .W (1 + PATHS)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({path_overtemp, attach_pin}),
    .dout    ({path_ot_s, attach_s})
  );

  spm_power_calc u_calc (
    .min_voltage_strap (strap_s[2:0]),
    .max_voltage_strap (strap_s[5:3]),
    .max_current_strap (strap_s[8:6]),
    .min_volt          (min_volt),
    .max_volt          (max_volt),
    .max_cur           (max_cur),
    .strap_bad         (strap_bad),
    .min_power         (min_p),
    .max_power         (max_p)
  );

  // Any of the six sources counts as activity. [R5]
  assign activity = pd_msg_evt | cc_change_evt | gpio_evt | i2c_evt | volt_alert | fault_alert;

  // The gap between set and clear levels keeps the shutdown from chattering. [R8] [R9]
  assign tsd_low = `SPM_TSD_THRESH - `SPM_TSD_HYST;
  assign tsd_set = (die_temp >= `SPM_TSD_THRESH);
  assign tsd_clr = (die_temp < tsd_low);
  assign run     = ~tsd_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tsd_q <= 1'b0;
    end else if (!tsd_q && tsd_set) begin
      tsd_q <= 1'b1; // [R8]
    end else if (tsd_q && tsd_clr) begin
      tsd_q <= 1'b0; // [R9]
    end
  end

  // Next-state logic has no command input; activity and attach alone steer it. [R3]
  always @* begin
    state_d = state_q;
    case (state_q)
      `SPM_ST_ACTIVE: begin
        if (!activity && idle_cnt_q >= IDLE_CYC - 32'h1) begin
          state_d = `SPM_ST_IDLE; // [R5]
        end
      end
      `SPM_ST_IDLE: begin
        if (activity) begin
          state_d = `SPM_ST_ACTIVE; // [R14]
        end else if (!attach_s) begin
          state_d = `SPM_ST_SLEEP;
        end
      end
      `SPM_ST_SLEEP: begin
        if (attach_s || activity) begin
          state_d = `SPM_ST_ACTIVE; // [R6]
        end
      end
      default: state_d = `SPM_ST_ACTIVE; // [R2]
    endcase
  end

  // A shutdown holds the machine in Sleep so it restarts cleanly afterwards. [R15]
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= `SPM_ST_ACTIVE;
    end else if (tsd_q) begin
      state_q <= `SPM_ST_SLEEP; // [R8]
    end else begin
      state_q <= state_d; // [R2]
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_cnt_q <= 32'h0;
    end else if (activity || state_q != `SPM_ST_ACTIVE) begin
      idle_cnt_q <= 32'h0; // [R14]
    end else if (idle_cnt_q < IDLE_CYC) begin
      idle_cnt_q <= idle_cnt_q + 32'h1; // [R5]
    end
  end

  // Deep standby is a flag beside Idle, entered after a further quiet spell. [R4]
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stby_cnt_q <= 32'h0;
      stby_q     <= 1'b0;
    end else if (state_q != `SPM_ST_IDLE || activity || !stby_en_q) begin
      stby_cnt_q <= 32'h0;
      stby_q     <= 1'b0; // [R4]
    end else if (stby_cnt_q < STBY_CYC - 32'h1) begin
      stby_cnt_q <= stby_cnt_q + 32'h1;
    end else begin
      stby_q <= 1'b1; // [R4]
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      attach_q    <= 1'b0;
      path_ot_q   <= {PATHS{1'b0}};
      strap_bad_q <= 1'b0;
    end else begin
      attach_q    <= attach_s;
      path_ot_q   <= path_ot_s; // [R10]
      strap_bad_q <= strap_bad;
    end
  end

  // Outputs are registered from the current state so pins and state change together.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_state                <= `SPM_ST_ACTIVE;
      deep_standby             <= 1'b0;
      thermal_shutdown         <= 1'b0;
      internal_hv_sink_path    <= 1'b0;
      external_path_gate_drive <= 1'b0;
      cc1_rp_en                <= 1'b0;
      cc2_rp_en                <= 1'b0;
    end else begin
      pwr_state                <= state_q;
      deep_standby             <= stby_q;
      thermal_shutdown         <= tsd_q;
      internal_hv_sink_path    <= run && state_q != `SPM_ST_SLEEP && !stby_q && !path_ot_s[0]; // [R7] [R10] [R15]
      external_path_gate_drive <= run && state_q != `SPM_ST_SLEEP && !stby_q && !path_ot_s[PATHS-1]; // [R7] [R10]
      cc1_rp_en                <= run && state_q != `SPM_ST_SLEEP && !stby_q; // [R7] [R15]
      cc2_rp_en                <= 1'b0; // [R7]
    end
  end

  // Power figures follow the straps every cycle; operational equals maximum.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      min_power_figure <= 8'h00;
      op_power_figure  <= 8'h00;
      max_power_figure <= 8'h00;
    end else begin
      min_power_figure <= min_p; // [R1]
      op_power_figure  <= max_p; // [R1]
      max_power_figure <= max_p; // [R1]
    end
  end

  always @* begin
    irq_evt                   = {`SPM_IRQ_W{1'b0}};
    irq_evt[`SPM_IRQ_STATE]   = (state_d != state_q) && run;
    irq_evt[`SPM_IRQ_TSD]     = !tsd_q && tsd_set;
    irq_evt[`SPM_IRQ_PATH_OT] = |(path_ot_s & ~path_ot_q);
    irq_evt[`SPM_IRQ_ATTACH]  = attach_s && !attach_q;
    irq_evt[`SPM_IRQ_STRAP]   = strap_bad && !strap_bad_q; // [R13]
  end

  // A read clears status, but an event in that same cycle still sets its bit.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_q <= {`SPM_IRQ_W{1'b0}};
    end else if (rd_stb && addr == `SPM_A_IRQ_STAT) begin
      irq_stat_q <= irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_mask_q <= {`SPM_IRQ_W{1'b0}};
      stby_en_q  <= 1'b0;
    end else if (wr_stb) begin
      if (addr == `SPM_A_CTRL) begin
        stby_en_q <= wr_data[`SPM_CTRL_STBY];
      end else if (addr == `SPM_A_IRQ_MASK) begin
        irq_mask_q <= wr_data[`SPM_IRQ_W-1:0];
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Unmapped addresses read as zero.
  always @* begin
    rd_d = 32'h0;
    if (addr == `SPM_A_CTRL) begin
      rd_d = {31'h0, stby_en_q};
    end else if (addr == `SPM_A_STATUS) begin
      rd_d = {{(27-PATHS){1'b0}}, path_ot_q, attach_q, tsd_q, stby_q, state_q};
    end else if (addr == `SPM_A_POWER) begin
      rd_d = {16'h0, max_p, min_p};
    end else if (addr == `SPM_A_VOLTS) begin
      rd_d = {14'h0, max_cur, 1'b0, max_volt, 3'h0, min_volt};
    end else if (addr == `SPM_A_IRQ_STAT) begin
      rd_d = {27'h0, irq_stat_q};
    end else if (addr == `SPM_A_IRQ_MASK) begin
      rd_d = {27'h0, irq_mask_q};
    end else if (addr == `SPM_A_STRAPS) begin
      rd_d = {20'h0, strap_s}; // [R12]
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0;
    end else if (rd_stb) begin
      rd_data <= rd_d;
    end else begin
      rd_data <= 32'h0;
    end
  end
endmodule // spm_top

// >>> bench/spm_asserts.sv
// Checker on the ports of the sink power state manager.
`timescale 1ns/10ps
module spm_asserts #(
  parameter [31:0] IDLE_CYC = 32'h10
) (
  input wire       clk_sys,
  input wire       rst,
  input wire       pd_msg_evt,
  input wire       cc_change_evt,
  input wire       gpio_evt,
  input wire       i2c_evt,
  input wire       volt_alert,
  input wire       fault_alert,
  input wire       attach_pin,
  input wire [7:0] die_temp,
  input wire [1:0] pwr_state,
  input wire       deep_standby,
  input wire       thermal_shutdown,
  input wire       internal_hv_sink_path,
  input wire       external_path_gate_drive,
  input wire       cc1_rp_en,
  input wire       cc2_rp_en
);
  wire act = pd_msg_evt | cc_change_evt | gpio_evt | i2c_evt | volt_alert | fault_alert;
  wire off = !internal_hv_sink_path && !external_path_gate_drive && !cc1_rp_en;
  reg  [31:0] quiet_q;
  // Counts edges since the last activity, so an early drop to Idle shows up.
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      quiet_q <= 32'h0;
    else
      quiet_q <= act ? 32'h0 : quiet_q + 32'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_one_state; pwr_state != 2'h3; endproperty
  property p_cc2_open; cc2_rp_en == 1'b0; endproperty
  property p_sleep_off; pwr_state == 2'h2 && $past(pwr_state) == 2'h2 |-> off; endproperty
  property p_tsd_off; thermal_shutdown && $past(thermal_shutdown) |-> off && pwr_state == 2'h2; endproperty
  property p_stby; deep_standby && $past(deep_standby) |-> pwr_state == 2'h1 && off; endproperty
  property p_tsd_set; die_temp >= 8'h7D |-> ##[1:3] thermal_shutdown; endproperty
  property p_tsd_hold; thermal_shutdown && die_temp >= 8'h6E |=> thermal_shutdown; endproperty
  property p_quiet; pwr_state == 2'h1 && $past(pwr_state) == 2'h0 |-> quiet_q >= IDLE_CYC; endproperty
  property p_wake; pwr_state == 2'h1 && act |-> ##[1:4] pwr_state != 2'h1; endproperty
  property p_attach; pwr_state == 2'h2 && $rose(attach_pin) && !thermal_shutdown |-> ##[1:10] pwr_state == 2'h0;
  endproperty
  a_one_state: assert property (p_one_state) else $error("illegal power state");
  a_cc2_open: assert property (p_cc2_open) else $error("cc2 termination not open");
  a_sleep_off: assert property (p_sleep_off) else $error("path or cc1 on in sleep");
  a_tsd_off: assert property (p_tsd_off) else $error("outputs on in shutdown");
  a_stby: assert property (p_stby) else $error("standby outside idle or path on");
  a_tsd_set: assert property (p_tsd_set) else $error("shutdown missed");
  a_tsd_hold: assert property (p_tsd_hold) else $error("shutdown left inside hysteresis");
  a_quiet: assert property (p_quiet) else $error("idle entered too early");
  a_wake: assert property (p_wake) else $error("activity did not end idle");
  a_attach: assert property (p_attach) else $error("attach did not wake sleep");
  c_idle: cover property (pwr_state == 2'h1);
  c_sleep: cover property (pwr_state == 2'h2);
  c_tsd: cover property (thermal_shutdown);
  c_stby: cover property (deep_standby);
endmodule // spm_asserts

// >>> bench/spm_pd_source.sv
// Behavioural source port driving attach, CC changes and PD messages.
`timescale 1ns/10ps
module spm_pd_source (
  input  wire clk_sys,
  input  wire attach_req,
  input  wire msg_req,
  output reg  attach_pin,
  output reg  pd_msg_evt,
  output reg  cc_change_evt
);
  initial begin
    attach_pin = 1'b1;
    pd_msg_evt = 1'b0;
    cc_change_evt = 1'b0;
  end
  // A plug or unplug always shows as a CC status change, as on a real port.
  always @(posedge clk_sys) begin
    cc_change_evt <= attach_req != attach_pin;
    attach_pin <= attach_req;
    pd_msg_evt <= msg_req;
  end
endmodule // spm_pd_source

// >>> bench/sink_power_state_manager_bench.sv
// Self-checking bench for the sink power state manager.
`timescale 1ns/10ps
`include "spm_defines.vh"
module sink_power_state_manager_bench;
  reg         clk_sys = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, att = 1'b1;
  reg  [7:0]  addr = 8'h00, temp = 8'h30;
  reg  [31:0] wr_data = 32'h0, d;
  reg  [2:0]  minv = 3'h0, maxv = 3'h0, opc = 3'h0, maxc = 3'h0;
  reg  [4:0]  evt = 5'h00;
  reg  [1:0]  pot = 2'h0;
  wire [31:0] rd_data;
  wire [1:0]  st;
  wire [7:0]  pmin, pop, pmax;
  wire        stby, tsd, hv, ext, cc1, cc2, irq, attach, msg, ccc;
  int         n_fail = 0, checks = 0, k;
  logic [7:0] vmin_t [0:7] = '{8'h05, 8'h09, 8'h0C, 8'h0F, 8'h14, 8'h05, 8'h05, 8'h05};
  logic [7:0] vmax_t [0:3] = '{8'h09, 8'h0C, 8'h0F, 8'h14};
  logic [7:0] ihalf_t [0:3] = '{8'h03, 8'h06, 8'h08, 8'h0A};
  always #10 clk_sys = ~clk_sys;
  spm_pd_source spm_pd_source_i (.clk_sys(clk_sys), .attach_req(att), .msg_req(evt[0]), .attach_pin(attach),
    .pd_msg_evt(msg), .cc_change_evt(ccc));
  spm_top #(.IDLE_CYC(32'h10), .STBY_CYC(32'h8)) spm_top_i (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .min_voltage_strap(minv),
    .max_voltage_strap(maxv), .operating_current_strap(opc), .max_current_strap(maxc), .pd_msg_evt(msg),
    .cc_change_evt(ccc), .gpio_evt(evt[1]), .i2c_evt(evt[2]), .volt_alert(evt[3]), .fault_alert(evt[4]),
    .attach_pin(attach), .die_temp(temp), .path_overtemp(pot), .pwr_state(st), .deep_standby(stby),
    .thermal_shutdown(tsd), .internal_hv_sink_path(hv), .external_path_gate_drive(ext), .cc1_rp_en(cc1),
    .cc2_rp_en(cc2), .min_power_figure(pmin), .op_power_figure(pop), .max_power_figure(pmax), .irq(irq));
  // Power figures in half-watt units: volts times half-amperes.
  function automatic [7:0] pw(input [7:0] v, input [2:0] c);
    pw = v * ihalf_t[c[1:0]];
  endfunction
  task automatic final_report;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic pulse(input int b);
    @(posedge clk_sys);
    evt[b] <= 1'b1;
    @(posedge clk_sys);
    evt <= 5'h00;
  endtask
  task automatic wait_st(input [1:0] s, input int n);
    for (int i = 0; i < n && st !== s; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("pwr_state", st, s);
    if (st !== s) final_report();
  endtask
  task automatic outs(input [2:0] e);
    #1 chk("path_cc1_cc2", {hv, cc1, cc2}, e);
  endtask
  initial begin
    void'($urandom(37730));
    cyc(8);
    rst <= 1'b0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      minv <= (k == 0) ? 3'h0 : 3'($urandom);
      maxv <= (k == 0) ? 3'h6 : 3'($urandom);
      opc <= (k == 0) ? 3'h3 : 3'($urandom);
      maxc <= (k == 0) ? 3'h3 : 3'($urandom);
      cyc(8);
      #1 chk("min_power", pmin, pw(vmin_t[minv], maxc));
      chk("op_power", pop, pw(vmax_t[maxv[2:1]], maxc));
      chk("max_power", pmax, pw(vmax_t[maxv[2:1]], maxc));
      rd(`SPM_A_POWER);
      chk("power_reg", d, {16'h0, pw(vmax_t[maxv[2:1]], maxc), pw(vmin_t[minv], maxc)});
    end
    for (k = 0; k < 5; k++) begin
      cyc(12);
      pulse(k);
      cyc(12);
      #1 chk("active_kept", st, `SPM_ST_ACTIVE);
    end
    wr(`SPM_A_IRQ_MASK, 32'h0);
    rd(`SPM_A_IRQ_STAT);
    wait_st(`SPM_ST_IDLE, 30);
    outs(3'h6);
    chk("irq_masked", irq, 1'b0);
    wr(`SPM_A_IRQ_MASK, 32'h1);
    cyc(2);
    #1 chk("irq_on", irq, 1'b1);
    rd(`SPM_A_IRQ_STAT);
    chk("irq_stat", d[0], 1'b1);
    cyc(2);
    #1 chk("irq_clear", irq, 1'b0);
    rd(8'h40);
    chk("unmapped", d, 32'h0);
    pulse(2);
    wait_st(`SPM_ST_ACTIVE, 4);
    wr(`SPM_A_CTRL, 32'h1);
    wait_st(`SPM_ST_IDLE, 30);
    cyc(20);
    #1 chk("deep_standby", {stby, st}, {1'b1, `SPM_ST_IDLE});
    outs(3'h0);
    wr(`SPM_A_CTRL, 32'h0);
    @(posedge clk_sys);
    att <= 1'b0;
    wait_st(`SPM_ST_SLEEP, 60);
    outs(3'h0);
    @(posedge clk_sys);
    att <= 1'b1;
    wait_st(`SPM_ST_ACTIVE, 12);
    @(posedge clk_sys);
    temp <= 8'h7D;
    cyc(5);
    #1 chk("tsd_set", {tsd, st, ext}, {1'b1, `SPM_ST_SLEEP, 1'b0});
    outs(3'h0);
    @(posedge clk_sys);
    temp <= 8'h6E;
    cyc(5);
    #1 chk("tsd_hold", tsd, 1'b1);
    @(posedge clk_sys);
    temp <= 8'h6D;
    cyc(5);
    #1 chk("tsd_clear", tsd, 1'b0);
    wait_st(`SPM_ST_ACTIVE, 12);
    @(posedge clk_sys);
    pot <= 2'h1;
    cyc(7);
    #1 chk("path_ot0", {hv, ext}, 2'h1);
    @(posedge clk_sys);
    pot <= 2'h2;
    cyc(7);
    #1 chk("path_ot1", {hv, ext}, 2'h2);
    final_report();
  end
endmodule // sink_power_state_manager_bench
bind spm_top spm_asserts #(.IDLE_CYC(IDLE_CYC)) spm_asserts_i (.clk_sys(clk_sys), .rst(rst),
  .pd_msg_evt(pd_msg_evt), .cc_change_evt(cc_change_evt), .gpio_evt(gpio_evt), .i2c_evt(i2c_evt),
  .volt_alert(volt_alert), .fault_alert(fault_alert), .attach_pin(attach_pin), .die_temp(die_temp),
  .pwr_state(pwr_state), .deep_standby(deep_standby), .thermal_shutdown(thermal_shutdown),
  .internal_hv_sink_path(internal_hv_sink_path), .external_path_gate_drive(external_path_gate_drive),
  .cc1_rp_en(cc1_rp_en), .cc2_rp_en(cc2_rp_en));
